// *** hdl/cdl_unit.sv ***
// Channel code delay unit: source select, tap clock, two delay lines
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1 - Source select picks previous channel or local code
// RULE2 - Time-mux mode forces local code into line 2; with swap set it goes to line 1
// RULE3 - Swap bit crosses inputs onto delay lines
// RULE4 - Tap clock from previous channel or local
// RULE5 - Local tap clock is core clock over divider+1
// RULE6 - Common sync pulse realigns divider counter phase
// RULE7 - Divided resampling adds up to divider cycles lag
// RULE8 - Two identical lines advanced by tap clock
// RULE9 - Each line: five cascaded 22-stage shift registers
// RULE10 - Replica spacing programmable from 1 to 22 taps
// RULE11 - Five replicas: very early through very late
// RULE12 - Route bit set: lines drive chained outputs
// RULE13 - Route bit clear: chained inputs bypass to outputs
// RULE14 - Replica path two bits, low bit enable only
// RULE15 - Reset clears shift registers and divider counter
module cdl_unit #(
	parameter int FIFO_DEPTH = cdl_pkg::CDL_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire cdl_pkg::cdl_ctrl_t code_delay_control_i,
	input wire logic time_mux_code_enable_i,
	input wire logic local_code_1_i,
	input wire logic local_code_2_i,
	input wire logic local_code_valid_i,
	output logic local_code_ready_o,
	input wire logic chained_code_in_1_i,
	input wire logic chained_code_in_2_i,
	input wire logic tap_clock_prev_i,
	input wire logic divider_phase_sync_i,
	output var cdl_pkg::cdl_replica_t replicas_o,
	output logic chained_code_out_1_o,
	output logic chained_code_out_2_o,
	output logic tap_clock_o
);

	import cdl_pkg::*;

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("cdl_unit: FIFO_DEPTH must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	// Tap selection within one segment, clamped to the segment length
	function automatic logic pick_tap(
		input logic [CDL_SEG_LEN-1:0] seg,
		input logic [CDL_SP_W-1:0] sp
	);
		logic [CDL_SP_W-1:0] idx;
		idx = (sp > CDL_SP_MAX) ? CDL_SP_MAX : sp;
		pick_tap = seg[idx];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Control decode
	logic src_prev;
	logic swap;
	logic clk_prev;
	logic route_lines;
	logic tmux;
	logic [CDL_DIV_W-1:0] div;

	assign src_prev = code_delay_control_i.code_source_select;
	assign swap = code_delay_control_i.input_swap_select;
	assign clk_prev = code_delay_control_i.tap_clock_source_select;
	assign route_lines = code_delay_control_i.output_route_select;
	assign tmux = time_mux_code_enable_i;
	assign div = code_delay_control_i.tap_clock_divider;

	////////////////////////////////////////////////////////////////////////
	// Tap clock enable
	logic [CDL_DIV_W-1:0] div_cnt_q;
	logic [CDL_DIV_W-1:0] div_cnt_d;
	logic local_tick;
	logic tap_tick;
	logic tap_clock_q;

	// RULE5 divide by div+1
	assign local_tick = div_cnt_q == div;
	// RULE6 sync restarts the count
	assign div_cnt_d = (divider_phase_sync_i || local_tick) ? CDL_DIV_RST :
		CDL_DIV_W'(div_cnt_q + 1'b1);
	// RULE4 tap clock source
	assign tap_tick = clk_prev ? tap_clock_prev_i : local_tick;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			// RULE15 divider cleared
			div_cnt_q <= CDL_DIV_RST;
			tap_clock_q <= 1'b0;
		end else begin
			div_cnt_q <= div_cnt_d;
			tap_clock_q <= tap_tick;
		end
	end

	assign tap_clock_o = tap_clock_q;

	////////////////////////////////////////////////////////////////////////
	// Sample buffer; the generator stalls on a full buffer
	cdl_word_t word_in;
	cdl_word_t word;
	logic word_valid;
	logic pop;

	assign word_in = '{
		local_1: local_code_1_i,
		local_2: local_code_2_i,
		chained_1: chained_code_in_1_i,
		chained_2: chained_code_in_2_i
	};

	cdl_fifo #(
		.WIDTH(CDL_WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.in_data_i(word_in),
		.in_valid_i(local_code_valid_i),
		.in_ready_o(local_code_ready_o),
		.out_data_o(word),
		.out_valid_o(word_valid),
		.out_ready_i(tap_tick)
	);

	// RULE7 resampled on the slower tick, lag up to div cycles
	assign pop = tap_tick & word_valid;

	////////////////////////////////////////////////////////////////////////
	// Input routing
	logic in1;
	logic in2;
	logic [CDL_LINES-1:0] line_in;

	// RULE1 source select
	assign in1 = src_prev ? word.chained_1 : word.local_1;
	// RULE2 input 2 keeps local code under time-mux
	assign in2 = (src_prev && !tmux) ? word.chained_2 : word.local_2;
	// RULE3 input swap
	assign line_in[0] = swap ? in2 : in1;
	assign line_in[1] = swap ? in1 : in2;

	////////////////////////////////////////////////////////////////////////
	// Delay lines
	logic [CDL_LINES-1:0][CDL_SEG_NUM-1:0][CDL_SEG_LEN-1:0] seg_q;
	logic [CDL_LINES-1:0][CDL_SEG_NUM-1:0] seg_in;
	logic [CDL_LINES-1:0][CDL_SEG_NUM-1:0] tap;

	for (genvar l = 0; l < CDL_LINES; l++) begin : g_line
		for (genvar k = 0; k < CDL_SEG_NUM; k++) begin : g_seg
			// RULE9 segments cascade through the selected tap
			if (k == 0) begin : g_head
				assign seg_in[l][k] = line_in[l];
			end else begin : g_tail
				assign seg_in[l][k] = tap[l][k-1];
			end
			// RULE10 spacing per segment
			assign tap[l][k] = pick_tap(seg_q[l][k],
				code_delay_control_i.spacing[k]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			// RULE15 lines cleared
			seg_q <= '0;
		end else if (pop) begin
			// RULE8 both lines advance together
			for (int l = 0; l < CDL_LINES; l++) begin
				for (int k = 0; k < CDL_SEG_NUM; k++) begin
					seg_q[l][k] <= {seg_q[l][k][CDL_SEG_LEN-2:0],
						seg_in[l][k]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Replica and chained outputs
	cdl_replica_t rep_d;
	cdl_replica_t rep_q;
	logic [CDL_SEG_NUM-1:0][1:0] rep_pair;
	logic out1_d;
	logic out2_d;
	logic out1_q;
	logic out2_q;

	// RULE14 low bit only as time-mux chip enable
	for (genvar k = 0; k < CDL_SEG_NUM; k++) begin : g_rep
		assign rep_pair[k] = {tap[0][k], tmux & tap[1][k]};
	end

	// RULE11 five replicas in order
	assign rep_d = '{
		very_early_replica: rep_pair[0],
		early: rep_pair[1],
		prompt: rep_pair[2],
		late: rep_pair[3],
		very_late_replica: rep_pair[4]
	};

	// RULE12 lines drive the chain
	// RULE13 bypass for channel slaving
	assign out1_d = route_lines ? tap[0][CDL_SEG_NUM-1] : chained_code_in_1_i;
	assign out2_d = route_lines ? tap[1][CDL_SEG_NUM-1] : chained_code_in_2_i;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rep_q <= '0;
			out1_q <= 1'b0;
			out2_q <= 1'b0;
		end else begin
			rep_q <= rep_d;
			out1_q <= out1_d;
			out2_q <= out2_d;
		end
	end

	assign replicas_o = rep_q;
	assign chained_code_out_1_o = out1_q;
	assign chained_code_out_2_o = out2_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_src_prev;
		pop && !swap && src_prev |=>
			seg_q[0][0][0] == $past(word.chained_1);
	endproperty
	a_src_prev: assert property (p_src_prev) // RULE1
		else $error("line 1 did not take previous channel code");

	property p_tmux_local;
		pop && !swap && src_prev && tmux |=>
			seg_q[1][0][0] == $past(word.local_2);
	endproperty
	a_tmux_local: assert property (p_tmux_local) // RULE2
		else $error("line 2 did not keep local code in time-mux");

	property p_swap;
		pop && swap && !src_prev |=>
			seg_q[0][0][0] == $past(word.local_2) &&
			seg_q[1][0][0] == $past(word.local_1);
	endproperty
	a_swap: assert property (p_swap) // RULE3
		else $error("swapped inputs not crossed onto lines");

	property p_clk_prev;
		clk_prev && tap_clock_prev_i |=> tap_clock_o;
	endproperty
	a_clk_prev: assert property (p_clk_prev) // RULE4
		else $error("previous channel tap clock not followed");

	property p_div_count;
		!divider_phase_sync_i && !local_tick |=>
			div_cnt_q == CDL_DIV_W'($past(div_cnt_q) + 1'b1);
	endproperty
	a_div_count: assert property (p_div_count) // RULE5
		else $error("divider counter did not advance");

	property p_div_rate;
		!clk_prev && div == 2'h3 && div_cnt_q == 2'h0 &&
			!divider_phase_sync_i ##1
			(!clk_prev && div == 2'h3 && !divider_phase_sync_i)[*2]
			##1 (!clk_prev && div == 2'h3) |-> tap_tick;
	endproperty
	a_div_rate: assert property (p_div_rate) // RULE5
		else $error("divide by four tick missing");

	property p_sync;
		divider_phase_sync_i |=> div_cnt_q == CDL_DIV_RST;
	endproperty
	a_sync: assert property (p_sync) // RULE6
		else $error("sync pulse did not realign the divider");

	property p_hold;
		!pop |=> $stable(seg_q);
	endproperty
	a_hold: assert property (p_hold) // RULE8
		else $error("delay lines moved without a tap tick");

	property p_cascade;
		pop |=> seg_q[0][1][0] == $past(tap[0][0]) &&
			seg_q[1][4][0] == $past(tap[1][3]);
	endproperty
	a_cascade: assert property (p_cascade) // RULE9
		else $error("segment cascade broken");

	property p_route;
		route_lines |=> chained_code_out_1_o == $past(tap[0][4]) &&
			chained_code_out_2_o == $past(tap[1][4]);
	endproperty
	a_route: assert property (p_route) // RULE12
		else $error("lines not routed to chained outputs");

	property p_bypass;
		!route_lines |=>
			chained_code_out_1_o == $past(chained_code_in_1_i) &&
			chained_code_out_2_o == $past(chained_code_in_2_i);
	endproperty
	a_bypass: assert property (p_bypass) // RULE13
		else $error("chained inputs not bypassed");

	property p_low_bit;
		!tmux |=> !replicas_o.very_early_replica[0] &&
			!replicas_o.early[0] && !replicas_o.prompt[0] &&
			!replicas_o.late[0] && !replicas_o.very_late_replica[0];
	endproperty
	a_low_bit: assert property (p_low_bit) // RULE14
		else $error("replica low bit set outside time-mux mode");

	property p_prompt;
		1'b1 |=> replicas_o.prompt ==
			{$past(tap[0][2]), $past(tmux & tap[1][2])};
	endproperty
	a_prompt: assert property (p_prompt) // RULE11
		else $error("prompt replica mismatch");

	// Counter may overrun a lowered divider for up to three cycles
	property p_lag;
		!clk_prev && div == $past(div, 1) && div == $past(div, 2) &&
			div == $past(div, 3) |-> div_cnt_q <= div;
	endproperty
	a_lag: assert property (p_lag) // RULE7
		else $error("tap tick wait exceeds divider setting");

	property p_reset;
		disable iff (1'b0)
		!rstn_i |=> seg_q == '0 && div_cnt_q == CDL_DIV_RST;
	endproperty
	a_reset: assert property (p_reset) // RULE15
		else $error("reset left delay lines or divider set");

endmodule

`default_nettype wire

// *** hdl/cdl_pkg.sv ***
// Shared constants and carrier types of the code delay unit
package cdl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Delay line geometry
	localparam int CDL_LINES = 2;
	localparam int CDL_SEG_NUM = 5;
	localparam int CDL_SEG_LEN = 22;
	localparam int CDL_MAX_TAPS = CDL_SEG_NUM * CDL_SEG_LEN;
	localparam int CDL_SP_W = 5;
	// Spacing code n selects n + 1 taps; codes above this clamp
	localparam logic [CDL_SP_W-1:0] CDL_SP_MAX = 5'h15;

	////////////////////////////////////////////////////////////////////////
	// Tap clock divider
	localparam int CDL_DIV_W = 2;
	localparam logic [CDL_DIV_W-1:0] CDL_DIV_RST = 2'h0;
	localparam int CDL_SYNC_PERIOD = 12;

	////////////////////////////////////////////////////////////////////////
	// Input buffering
	localparam int CDL_FIFO_DEPTH = 16;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic code_source_select;
		logic input_swap_select;
		logic tap_clock_source_select;
		logic output_route_select;
		logic [CDL_DIV_W-1:0] tap_clock_divider;
		// Index 0 feeds very early, index 4 very late
		logic [CDL_SEG_NUM-1:0][CDL_SP_W-1:0] spacing;
	} cdl_ctrl_t;

	typedef struct packed {
		logic local_1;
		logic local_2;
		logic chained_1;
		logic chained_2;
	} cdl_word_t;

	localparam int CDL_WORD_W = $bits(cdl_word_t);

	// Bit 1 from line 1 (sign), bit 0 from line 2 (chip enable)
	typedef struct packed {
		logic [1:0] very_early_replica;
		logic [1:0] early;
		logic [1:0] prompt;
		logic [1:0] late;
		logic [1:0] very_late_replica;
	} cdl_replica_t;

endpackage

// *** hdl/cdl_fifo.sv ***
// Parameterised valid/ready FIFO for the code sample stream
`timescale 1ns/1ps
`default_nettype none

module cdl_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("cdl_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic ready_q;
	logic push;
	logic pop;

	assign push = in_valid_i & ready_q;
	assign pop = out_ready_i & out_valid_o;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem[rd_q];
	assign in_ready_o = ready_q;

	// Ready is registered so the source sees it straight from a flop
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_d;
			ready_q <= cnt_d != (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

endmodule

`default_nettype wire

// *** dv/cdl_code_src.sv ***
// Stand-in for the local code generator feeding the unit's buffer
`timescale 1ns/1ps
`default_nettype none

module cdl_code_src (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic slow_i,
	input wire logic hold_i,
	input wire logic [1:0] level_i,
	input wire logic ready_i,
	output logic code_1_o,
	output logic code_2_o,
	output logic valid_o
);
	logic live_q;
	wire logic offer = live_q && !hold_i && !(slow_i && valid_o);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			live_q <= 1'b0;
			valid_o <= 1'b0;
			{code_1_o, code_2_o} <= 2'h0;
		end else begin
			live_q <= 1'b1;
			// Word stays put until taken; idle data is inverted
			if (!valid_o || ready_i) begin
				valid_o <= offer;
				{code_1_o, code_2_o} <= offer ? level_i : ~level_i;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the channel code delay unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import cdl_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	cdl_ctrl_t ctrl = '0;
	logic tmux = 1'b0, ch1 = 1'b0, ch2 = 1'b0, prev = 1'b0, sync = 1'b0;
	logic slow = 1'b0, hold = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic c1, c2, vld, rdy, co1, co2, tck;
	logic [3:0] e;
	logic [4:0] sp;
	logic [4:0] sps [4] = '{5'h00, 5'h0A, 5'h15, 5'h1F};
	cdl_replica_t rep;
	int errors = 0, tests_run = 0, cyc = 0, pushes = 0, n, t0, want;
	// src swap route tmux loc1 loc2 ch1 ch2 | line1 line2 out1 out2
	logic [11:0] rows [6] = '{12'h28A, 12'hA3F, 12'hB6F, 12'h685,
		12'h166, 12'hD6E};

	cdl_code_src src_u (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
		.hold_i(hold), .level_i(lvl), .ready_i(rdy), .code_1_o(c1),
		.code_2_o(c2), .valid_o(vld));
	cdl_unit dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.code_delay_control_i(ctrl), .time_mux_code_enable_i(tmux),
		.local_code_1_i(c1), .local_code_2_i(c2),
		.local_code_valid_i(vld), .local_code_ready_o(rdy),
		.chained_code_in_1_i(ch1), .chained_code_in_2_i(ch2),
		.tap_clock_prev_i(prev), .divider_phase_sync_i(sync),
		.replicas_o(rep), .chained_code_out_1_o(co1),
		.chained_code_out_2_o(co2), .tap_clock_o(tck));

	always #4 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	// Time base sync, push count and hang guard
	always @(posedge clk_i) begin
		cyc++;
		sync <= #1 (cyc % CDL_SYNC_PERIOD == 0);
		if (!rstn_i) begin
			pushes = 0;
		end else if (vld === 1'b1 && rdy === 1'b1) begin
			pushes++;
		end
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	task automatic wrap_up;
		$display("counts: %0d compared, %0d wrong", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		step(8);
		check({rep, co1, co2, tck, rdy}, 16'h0000);
		rstn_i = 1'b1;
		step(1);
		check(rdy, 1'b1);
		$display("reset test done");
		// Routing table: long flush covers 110 taps at divide by 4
		for (int r = 0; r < 6; r++) begin
			{ctrl.code_source_select, ctrl.input_swap_select,
				ctrl.output_route_select, tmux, lvl, ch1, ch2} = rows[r][11:4];
			ctrl.tap_clock_divider = r[1:0];
			ctrl.spacing = {5{r[0] ? CDL_SP_MAX : 5'h00}};
			slow = r[1];
			step(600);
			e = rows[r][3:0];
			check(rep, {5{e[3], tmux & e[2]}});
			check({co1, co2}, e[1:0]);
			$display("row %0d done", r);
		end
		slow = 1'b0;
		// Sync period of 12 is a multiple of every divide ratio
		for (int d = 0; d < 4; d++) begin
			ctrl.tap_clock_divider = d[1:0];
			step(24);
			n = 0;
			repeat (48) begin
				step(1);
				n += tck;
			end
			check(n[15:0], 16'(48 / (d + 1)));
		end
		$display("divider test done");
		// Buffer fills while no tick arrives from the previous channel
		rstn_i = 1'b0;
		ctrl.tap_clock_source_select = 1'b1;
		step(2);
		check({rep, co1, co2, rdy}, 13'h0000);
		rstn_i = 1'b1;
		step(40);
		check(pushes[15:0], 16'(CDL_FIFO_DEPTH));
		check(rdy, 1'b0);
		hold = 1'b1;
		n = 0;
		repeat (20) begin
			prev = 1'b1;
			step(1);
			n += tck;
			prev = 1'b0;
			step(1);
			n += tck;
		end
		check(n[15:0], 16'h0014);
		check(rdy, 1'b1);
		hold = 1'b0;
		ctrl.tap_clock_source_select = 1'b0;
		$display("buffer test done");
		// Step edge: very late lags very early by four spacings
		{ctrl.code_source_select, ctrl.input_swap_select, tmux} = 3'h0;
		ctrl.output_route_select = 1'b1;
		// Last case uses an over-range code, held to one segment
		for (int k = 0; k < 4; k++) begin
			sp = sps[k];
			ctrl.spacing = {5{sp}};
			ctrl.tap_clock_divider = (k >= 2) ? 2'h3 : k[1:0];
			lvl = 2'h0;
			step(700);
			lvl = 2'h2;
			n = 0;
			t0 = -1;
			while (rep.very_late_replica[1] !== 1'b1 && n < 1000) begin
				step(1);
				n++;
				if (t0 < 0 && rep.very_early_replica[1] === 1'b1) begin
					t0 = n;
				end
			end
			want = 4 * ((sp > CDL_SP_MAX) ? CDL_SEG_LEN : sp + 1) *
				(ctrl.tap_clock_divider + 1);
			check(16'(n - t0), 16'(want));
		end
		$display("spacing test done");
		wrap_up();
	end
endmodule
`default_nettype wire
